// *** verilog/second_pulse_pkg.sv ***
// Constants, register map and carrier types of the second pulse generator
package second_pulse_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_KHZ         = 125000;      // Core clock, 8 ns period
  localparam int unsigned REF_NUM         = 26;          // Reference 26 MHz ...
  localparam int unsigned REF_DEN         = 125;         // ... over 125 MHz core
  localparam int unsigned REF_TICKS_US    = 26;          // One step is 38.5 ns
  localparam int unsigned SEC_TICKS       = 26000000;    // Reference steps per second
  localparam int unsigned SUPV_HOLD_MS    = 140;         // Supervisor hold after release
  localparam int unsigned SUPV_HOLD_CYC   = CLK_KHZ * SUPV_HOLD_MS;
  localparam int unsigned PW_DEF_US       = 1000;        // Default pulse width 1 ms
  localparam int unsigned PW_MAX_US       = 2500;        // Longest pulse 2.5 ms
  localparam int unsigned PW_MIN_TICKS    = 1;           // Shortest pulse 38.5 ns
  localparam int unsigned PW_DEF_TICKS    = PW_DEF_US * REF_TICKS_US;
  localparam int unsigned PW_MAX_TICKS    = PW_MAX_US * REF_TICKS_US;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] WIDTH_OFS  = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] OFFSET_OFS = 8'h0C;

  // Control fields
  localparam int unsigned CTRL_GATE_BIT = 0;
  localparam int unsigned CTRL_FALL_BIT = 1;
  localparam int unsigned CTRL_STD_LSB  = 2;
  localparam logic [1:0]  AXI_OKAY      = 2'h0;
  localparam logic [1:0]  AXI_DECERR    = 2'h3;

  // Time standards, UTC after reset
  typedef enum logic [1:0] {STD_UTC, STD_GPS, STD_GLONASS, STD_UTC_SU} time_std_t;

  typedef struct packed {
    time_std_t std_sel;
    logic      fall_mark;
    logic      fix_gate;
  } ctrl_t;

  localparam ctrl_t CTRL_RST = '{std_sel: STD_UTC, fall_mark: 1'b0, fix_gate: 1'b0};

endpackage : second_pulse_pkg

// *** verilog/second_pulse_generator.sv ***
// Once-per-second timing pulse generator with reset supervisor and AXI4-Lite registers
`timescale 1ns/1ns
`default_nettype none

module second_pulse_generator import second_pulse_pkg::*; #(
  parameter int unsigned HOLD_CYCLES  = SUPV_HOLD_CYC,
  parameter int unsigned SECOND_TICKS = SEC_TICKS
) (
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        RESET_N_PIN_IN,
  input  wire logic        FIX_VALID_IN,
  input  wire logic [3:0]  STD_SECOND_IN,
  output logic             SECOND_PULSE_OUT,
  output logic             DEV_RESET_OUT,
  input  wire logic [7:0]  S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  output logic             S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  output logic             S_AXI_WREADY_OUT,
  output logic [1:0]       S_AXI_BRESP_OUT,
  output logic             S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  input  wire logic [7:0]  S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  output logic             S_AXI_ARREADY_OUT,
  output logic [31:0]      S_AXI_RDATA_OUT,
  output logic [1:0]       S_AXI_RRESP_OUT,
  output logic             S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN
);

  // Second counter is 25 bits; a width longer than a second just retriggers
  if (HOLD_CYCLES < 1 || SECOND_TICKS < 2 || SECOND_TICKS > 33554432) begin : g_cfg_bad
    $error("second_pulse_generator: unusable hold or second count");
  end

  // ==========================================================================
  // Reset pin synchroniser and supervisor
  // ==========================================================================
  logic [2:0]  pin_sync_r, pin_sync_nxt;
  logic        pin_low_r, pin_low_nxt;
  logic [31:0] hold_cnt_r, hold_cnt_nxt;
  logic        dev_rst_r, dev_rst_nxt;

  // Pin level counts only once stages two and three agree
  always_comb begin
    pin_sync_nxt = {pin_sync_r[1:0], RESET_N_PIN_IN};
    pin_low_nxt  = pin_low_r;
    if (pin_sync_r[2] == pin_sync_r[1]) begin
      pin_low_nxt = ~pin_sync_r[2];
    end
    hold_cnt_nxt = hold_cnt_r;
    if (pin_low_r) begin
      hold_cnt_nxt = HOLD_CYCLES;
    end else if (hold_cnt_r != 32'h0000_0000) begin
      hold_cnt_nxt = hold_cnt_r - 32'h0000_0001;
    end
    dev_rst_nxt = pin_low_r || (hold_cnt_r > 32'h0000_0001);
  end

  // Power-on also starts the full hold, no host sequencing needed
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pin_sync_r <= 3'h7;
      pin_low_r  <= 1'b0;
      hold_cnt_r <= HOLD_CYCLES;
      dev_rst_r  <= 1'b1;
    end else begin
      pin_sync_r <= pin_sync_nxt;
      pin_low_r  <= pin_low_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      dev_rst_r  <= dev_rst_nxt;
    end
  end

  // ==========================================================================
  // 26 MHz step enable from the 125 MHz core clock
  // ==========================================================================
  logic [7:0] acc_r, acc_nxt;
  logic       tick_r, tick_nxt;

  // Fractional divider; steps jitter by one core cycle, averaging 26 MHz
  // Accumulator needs 8 bits: it reaches 124 + 26 before wrapping
  always_comb begin
    tick_nxt = 1'b0;
    acc_nxt  = acc_r + 8'(REF_NUM);
    if (acc_nxt >= 8'(REF_DEN)) begin
      acc_nxt  = acc_nxt - 8'(REF_DEN);
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      acc_r  <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      acc_r  <= acc_nxt;
      tick_r <= tick_nxt;
    end
  end

  // ==========================================================================
  // Second counter, alignment and pulse shaping
  // ==========================================================================
  ctrl_t       ctrl_r, ctrl_nxt;
  logic [16:0] width_r, width_nxt;
  logic [24:0] sec_cnt_r, sec_cnt_nxt;
  logic [16:0] wcnt_r, wcnt_nxt;
  logic        act_r, act_nxt;
  logic        align_r, align_nxt;
  logic        locked_r, locked_nxt;
  logic [31:0] offset_r, offset_nxt;
  logic        out_r, out_nxt;
  logic        std_hit;
  logic        mark;
  logic        gated;

  assign std_hit = FIX_VALID_IN && STD_SECOND_IN[ctrl_r.std_sel];
  assign mark    = tick_r && (align_r || sec_cnt_r == 25'(SECOND_TICKS - 1));
  assign gated   = ctrl_r.fix_gate && !FIX_VALID_IN;

  always_comb begin
    sec_cnt_nxt = sec_cnt_r;
    wcnt_nxt    = wcnt_r;
    act_nxt     = act_r;
    align_nxt   = align_r || std_hit;
    locked_nxt  = locked_r && FIX_VALID_IN;
    offset_nxt  = offset_r;
    // Offset is steps since the last own mark when the standard second arrives
    if (std_hit) begin
      offset_nxt = {7'h00, sec_cnt_r};
      locked_nxt = 1'b1;
    end
    if (tick_r) begin
      sec_cnt_nxt = mark ? 25'h000_0000 : sec_cnt_r + 25'h000_0001;
      if (mark) begin
        align_nxt = std_hit;
      end
      if (act_r) begin
        wcnt_nxt = wcnt_r - 17'h0_0001;
        act_nxt  = (wcnt_r != 17'h0_0001);
      end
      if (mark && !gated) begin
        act_nxt  = 1'b1;
        wcnt_nxt = width_r;
      end
    end
    out_nxt = act_r ^ ctrl_r.fall_mark;
    if (dev_rst_r) begin
      sec_cnt_nxt = 25'h000_0000;
      act_nxt     = 1'b0;
      align_nxt   = 1'b0;
      locked_nxt  = 1'b0;
      out_nxt     = ctrl_r.fall_mark;
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sec_cnt_r <= 25'h000_0000;
      wcnt_r    <= 17'h0_0000;
      act_r     <= 1'b0;
      align_r   <= 1'b0;
      locked_r  <= 1'b0;
      offset_r  <= 32'h0000_0000;
      out_r     <= 1'b0;
    end else begin
      sec_cnt_r <= sec_cnt_nxt;
      wcnt_r    <= wcnt_nxt;
      act_r     <= act_nxt;
      align_r   <= align_nxt;
      locked_r  <= locked_nxt;
      offset_r  <= offset_nxt;
      out_r     <= out_nxt;
    end
  end

  assign SECOND_PULSE_OUT = out_r;
  assign DEV_RESET_OUT    = dev_rst_r;

  // ==========================================================================
  // AXI4-Lite slave
  // ==========================================================================
  logic        aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [7:0]  awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        wr_go;
  logic [31:0] wval;

  assign wr_go = aw_have_r && w_have_r && !bvalid_r;
  assign wval  = wdata_r;

  // Address and data may arrive in either order; response once both held
  always_comb begin
    aw_have_nxt = aw_have_r || S_AXI_AWVALID_IN;
    awaddr_nxt  = aw_have_r ? awaddr_r : S_AXI_AWADDR_IN;
    w_have_nxt  = w_have_r || S_AXI_WVALID_IN;
    wdata_nxt   = w_have_r ? wdata_r : S_AXI_WDATA_IN;
    bvalid_nxt  = bvalid_r && !S_AXI_BREADY_IN;
    bresp_nxt   = bresp_r;
    ctrl_nxt    = ctrl_r;
    width_nxt   = width_r;
    if (wr_go) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = AXI_OKAY;
      case (awaddr_r)
        CTRL_OFS: begin
          if (S_AXI_WSTRB_IN[0] || 1'b1) begin
            ctrl_nxt.fix_gate  = wval[CTRL_GATE_BIT];
            ctrl_nxt.fall_mark = wval[CTRL_FALL_BIT];
            ctrl_nxt.std_sel   = time_std_t'(wval[CTRL_STD_LSB +: 2]);
          end
        end
        WIDTH_OFS: begin
          // Out-of-range widths clamp rather than fault
          if (wval[31:0] < 32'(PW_MIN_TICKS)) begin
            width_nxt = 17'(PW_MIN_TICKS);
          end else if (wval > 32'(PW_MAX_TICKS)) begin
            width_nxt = 17'(PW_MAX_TICKS);
          end else begin
            width_nxt = wval[16:0];
          end
        end
        STATUS_OFS, OFFSET_OFS: begin
          bresp_nxt = AXI_OKAY;
        end
        default: begin
          bresp_nxt = AXI_DECERR;
        end
      endcase
    end
    rvalid_nxt = rvalid_r && !S_AXI_RREADY_IN;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (S_AXI_ARVALID_IN && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = AXI_OKAY;
      case (S_AXI_ARADDR_IN)
        CTRL_OFS:   rdata_nxt = {28'h000_0000, ctrl_r};
        WIDTH_OFS:  rdata_nxt = {15'h0000, width_r};
        STATUS_OFS: rdata_nxt = {27'h000_0000, locked_r, act_r, dev_rst_r,
                                 out_r, FIX_VALID_IN};
        OFFSET_OFS: rdata_nxt = offset_r;
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = AXI_DECERR;
        end
      endcase
    end
  end

  // Registers live on the bus reset only; device reset leaves settings kept
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      bvalid_r  <= 1'b0;
      bresp_r   <= AXI_OKAY;
      rvalid_r  <= 1'b0;
      rresp_r   <= AXI_OKAY;
      rdata_r   <= 32'h0000_0000;
      ctrl_r    <= CTRL_RST;
      width_r   <= 17'(PW_DEF_TICKS);
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
      ctrl_r    <= ctrl_nxt;
      width_r   <= width_nxt;
    end
  end

  assign S_AXI_AWREADY_OUT = !aw_have_r;
  assign S_AXI_WREADY_OUT  = !w_have_r;
  assign S_AXI_BVALID_OUT  = bvalid_r;
  assign S_AXI_BRESP_OUT   = bresp_r;
  assign S_AXI_ARREADY_OUT = !rvalid_r;
  assign S_AXI_RVALID_OUT  = rvalid_r;
  assign S_AXI_RDATA_OUT   = rdata_r;
  assign S_AXI_RRESP_OUT   = rresp_r;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);

  hold_after_release_a: assert property (
    $fell(pin_low_r) |-> dev_rst_r [*8]
  ) else $error("device left reset too early after pin release");

  supervisor_holds_a: assert property (
    (hold_cnt_r > 32'h0000_0002) |=> dev_rst_r
  ) else $error("reset dropped while hold count running");

  runs_when_idle_a: assert property (
    (!pin_low_r && hold_cnt_r == 32'h0000_0000) |=> !dev_rst_r
  ) else $error("device stuck in reset with pin inactive");

  idle_in_reset_a: assert property (
    dev_rst_r |=> (SECOND_PULSE_OUT == $past(ctrl_r.fall_mark)) && !act_r
  ) else $error("pulse active during device reset");

  step_rate_a: assert property (
    tick_r |=> !tick_r ##1 !tick_r ##1 !tick_r
  ) else $error("reference steps too close");

  second_span_a: assert property (
    sec_cnt_r < 25'(SECOND_TICKS)
  ) else $error("second counter overran");

  mark_starts_a: assert property (
    (mark && !gated && !dev_rst_r) |=> act_r && wcnt_r == $past(width_r)
  ) else $error("mark did not start pulse");

  gate_blocks_a: assert property (
    (mark && gated && !act_r && !dev_rst_r) |=> !act_r
  ) else $error("pulse emitted without fix while gated");

  width_ends_a: assert property (
    (tick_r && act_r && wcnt_r == 17'h0_0001 && !mark) |=> !act_r
  ) else $error("pulse width overran");

  width_range_a: assert property (
    width_r >= 17'(PW_MIN_TICKS) && width_r <= 17'(PW_MAX_TICKS)
  ) else $error("pulse width register out of range");

  offset_capture_a: assert property (
    (std_hit && !dev_rst_r) |=> offset_r == {7'h00, $past(sec_cnt_r)} && align_r
  ) else $error("offset not captured at standard second");

  polarity_a: assert property (
    !dev_rst_r |=> SECOND_PULSE_OUT == ($past(act_r) ^ $past(ctrl_r.fall_mark))
  ) else $error("output polarity wrong");

  pulse_seen_c:    cover property (!act_r ##1 act_r);
  align_seen_c:    cover property (std_hit ##[1:20] mark);
  pin_reset_c:     cover property (pin_low_r ##1 !pin_low_r);
  bad_addr_c:      cover property (bvalid_r && bresp_r == AXI_DECERR);

endmodule : second_pulse_generator

`default_nettype wire

// *** testbench/host_side_model.sv ***
// Host side model: drives the reset pin and counts timing pulses
`timescale 1ns/1ns
`default_nettype none

module host_side_model #(
  parameter int unsigned LOW_CYCLES = 125000
) (
  input  wire logic clk_in,
  input  wire logic reset_req_in,
  input  wire logic pulse_in,
  output var logic  reset_n_pin_out,
  output var int    pulse_count_out
);
  // ==========================================================================
  // Reset pin
  // ==========================================================================
  int unsigned low_cnt_r = 0;
  logic        pulse_d_r = 1'b0;

  // Idle high so the card runs; a request gives one long low pulse
  initial reset_n_pin_out = 1'b1;
  always @(posedge clk_in) begin
    if (reset_req_in && low_cnt_r == 0) begin
      reset_n_pin_out <= 1'b0;
      low_cnt_r <= LOW_CYCLES;
    end else if (low_cnt_r > 1) begin
      low_cnt_r <= low_cnt_r - 1;
    end else if (low_cnt_r == 1) begin
      low_cnt_r <= 0;
      reset_n_pin_out <= 1'b1;
    end
  end

  // ==========================================================================
  // Pulse receiver
  // ==========================================================================
  // Rising edges only, as a host latch would see them
  initial pulse_count_out = 0;
  always @(posedge clk_in) begin
    pulse_d_r <= pulse_in;
    if (pulse_in && !pulse_d_r) begin
      pulse_count_out <= pulse_count_out + 1;
    end
  end
endmodule : host_side_model

`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking bench for the second pulse generator
`timescale 1ns/1ns
`default_nettype none

module tb;
  import second_pulse_pkg::*;
  // Short counts keep the run small
  localparam int HOLD  = 50;
  localparam int TICKS = 500;
  localparam int LOW   = 20;
  localparam int PER   = TICKS * 125 / 26;

  logic        clk = 1'b0, rst = 1'b1, fix = 1'b0, req = 1'b0, idle = 1'b0;
  logic [3:0]  stdm = 4'h0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  wire logic   pin_n, pulse, dev_rst, awr, wr, bv, arr, rv;
  wire logic [1:0]  br, rr;
  wire logic [31:0] rd;
  int          pcnt, err_count = 0, n_tests = 0, cyc = 0, bad_rst = 0;

  second_pulse_generator #(.HOLD_CYCLES(HOLD), .SECOND_TICKS(TICKS)) second_pulse_generator_inst (
    .CORE_CLK_IN(clk), .RST_IN(rst), .RESET_N_PIN_IN(pin_n), .FIX_VALID_IN(fix),
    .STD_SECOND_IN(stdm), .SECOND_PULSE_OUT(pulse), .DEV_RESET_OUT(dev_rst),
    .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
    .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv),
    .S_AXI_WREADY_OUT(wr), .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv),
    .S_AXI_BREADY_IN(bre), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
    .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rd), .S_AXI_RRESP_OUT(rr),
    .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rre));

  host_side_model #(.LOW_CYCLES(LOW)) host_side_model_inst (
    .clk_in(clk), .reset_req_in(req), .pulse_in(pulse),
    .reset_n_pin_out(pin_n), .pulse_count_out(pcnt));

  // ==========================================================================
  // Clock, cycle count, reset watch
  // ==========================================================================
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  // An active pulse output while the device is held in reset is a fault
  always @(negedge clk) if (dev_rst === 1'b1 && pulse !== idle) bad_rst++;

  // ==========================================================================
  // Checks and verdict
  // ==========================================================================
  task automatic check_eq(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask : check_eq

  task automatic check_rng(input string nm, input int lo, input int hi, input int g);
    n_tests++;
    if (g < lo || g > hi) begin
      err_count++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", nm, lo, hi, g);
    end
  endtask : check_rng

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // ==========================================================================
  // Bus tasks: readies sampled at the falling edge hold until the next rise
  // ==========================================================================
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha, hw, hb;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(negedge clk);
      ha = awv && awr;
      hw = wv && wr;
      hb = bv;
      r = br;
      @(posedge clk);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
      if (hb) bre <= 1'b0;
    end while (!hb);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(negedge clk);
      ha = arv && arr;
      hr = rv;
      d = rd;
      r = rr;
      @(posedge clk);
      if (ha) arv <= 1'b0;
      if (hr) rre <= 1'b0;
    end while (!hr);
  endtask : axi_rd

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    check_eq("bresp", AXI_OKAY, r);
  endtask : wr_chk

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    check_eq(nm, e, d);
  endtask : rd_chk

  // Bounded wait on the pulse (dev=0) or the device reset (dev=1)
  task automatic wait_for(input bit dev, input logic v, input int max, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((dev ? dev_rst : pulse) !== v && n < max);
  endtask : wait_for

  // Active time and period of one whole pulse
  task automatic measure(input logic act, output int hi, output int per);
    int lo;
    wait_for(0, !act, 4000, lo);
    wait_for(0, act, 4000, lo);
    wait_for(0, !act, 4000, hi);
    wait_for(0, act, 4000, lo);
    per = hi + lo;
  endtask : measure

  // ==========================================================================
  // Watchdog
  // ==========================================================================
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    give_verdict();
  end

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          n, hi, per, t, c0;
    int          wtab[2] = '{1, 10};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t = cyc;
    // Defaults and clamping, all inside the supervisor hold
    rd_chk("ctrl", CTRL_OFS, 32'h0);
    rd_chk("width", WIDTH_OFS, 32'd26000);
    wr_chk(WIDTH_OFS, 32'd0);
    rd_chk("width min", WIDTH_OFS, 32'd1);
    wr_chk(WIDTH_OFS, 32'd70000);
    rd_chk("width max", WIDTH_OFS, 32'd65000);
    wait_for(1, 1'b0, 200, n);
    check_rng("supervisor hold", HOLD, HOLD + 6, cyc - t);
    axi_rd(8'h10, d, r);
    check_eq("unmapped rresp", AXI_DECERR, r);
    check_eq("unmapped rdata", 32'h0, d);
    axi_wr(8'h10, 32'hFFFF_FFFF, r);
    check_eq("unmapped bresp", AXI_DECERR, r);
    // Free run without fix, shortest and a short width
    foreach (wtab[i]) begin
      wr_chk(WIDTH_OFS, wtab[i]);
      measure(1'b1, hi, per);
      check_rng("width", wtab[i] * 125 / 26 - 1, wtab[i] * 125 / 26 + 2, hi);
      check_rng("period", PER - 2, PER + 3, per);
    end
    // Falling marking edge
    wr_chk(CTRL_OFS, 32'h2);
    idle = 1'b1;
    measure(1'b0, hi, per);
    check_rng("fall width", 47, 50, hi);
    check_rng("fall period", PER - 2, PER + 3, per);
    // Gated without fix, then fix arrives; let the low pulse end first
    wait_for(0, 1'b1, 100, n);
    wr_chk(CTRL_OFS, 32'h1);
    idle = 1'b0;
    c0 = pcnt;
    wait_for(0, 1'b1, PER + 200, n);
    check_eq("gated pulses", c0, pcnt);
    @(posedge clk);
    fix <= 1'b1;
    measure(1'b1, hi, per);
    check_rng("fix period", PER - 2, PER + 3, per);
    // Alignment to each standard; others' marks must be ignored
    for (int s = 0; s < 4; s++) begin
      wr_chk(CTRL_OFS, 32'(s) << 2);
      wait_for(0, 1'b0, 100, n);
      wait_for(0, 1'b1, 4000, n);
      repeat (100) @(posedge clk);
      stdm <= ~(4'h1 << s);
      @(posedge clk);
      stdm <= 4'h0;
      repeat (99) @(posedge clk);
      stdm <= 4'h1 << s;
      @(posedge clk);
      stdm <= 4'h0;
      wait_for(0, 1'b1, 12, n);
      check_rng("aligned mark", 1, 9, n);
      axi_rd(OFFSET_OFS, d, r);
      check_rng("offset", 38, 46, int'(d));
    end
    axi_rd(STATUS_OFS, d, r);
    check_eq("status", 32'h1, d & 32'h5);
    // Pin reset between pulses, then restart from the internal scale
    wait_for(0, 1'b0, 100, n);
    @(posedge clk);
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    wait_for(1, 1'b1, 10, n);
    check_rng("pin reset entry", 1, 6, n);
    wait_for(1, 1'b0, 400, n);
    check_rng("pin reset hold", LOW + HOLD - 6, LOW + HOLD + 6, n);
    wait_for(0, 1'b1, 4000, n);
    check_rng("restart", PER - 10, PER + 10, n);
    rd_chk("width kept", WIDTH_OFS, 32'd10);
    check_eq("pulse in reset", 32'h0, bad_rst);
    give_verdict();
  end
endmodule : tb

`default_nettype wire
